// >>> core/grls_consts.vh
`ifndef GRLS_CONSTS_VH
`define GRLS_CONSTS_VH
// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define GRLS_OFS_CTRL 6'h00
`define GRLS_OFS_DSG_TH 6'h04
`define GRLS_OFS_CHG_TH 6'h08
`define GRLS_OFS_QUIT 6'h0C
`define GRLS_OFS_DSG_RLX 6'h10
`define GRLS_OFS_CHG_RLX 6'h14
`define GRLS_OFS_QUIT_RLX 6'h18
`define GRLS_OFS_CMD 6'h1C
`define GRLS_OFS_STATUS 6'h20
`define GRLS_OFS_QMAX 6'h24
`define GRLS_OFS_AVG_I 6'h28
`define GRLS_OFS_AVG_P 6'h2C
`define GRLS_OFS_RSV_E 6'h30
`define GRLS_OFS_DSN_E 6'h34
`define GRLS_OFS_RSV_MWH 6'h38
`define GRLS_OFS_DSN_MWH 6'h3C
// ----------------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------------
`define GRLS_CTRL_NOLOAD 0
`define GRLS_CTRL_SCALE_LO 8
`define GRLS_CTRL_SCALE_HI 11
`define GRLS_SCALE_MIN 4'h1
`define GRLS_SCALE_MAX 4'hA
`define GRLS_SCALE_RST 4'h1
`define GRLS_TH_RST 16'h0064
`define GRLS_QUIT_RST 16'h000A
`define GRLS_DSG_RLX_RST 16'h003C
`define GRLS_CHG_RLX_RST 16'h003C
`define GRLS_QUIT_RLX_RST 16'h0001
`define GRLS_QMAX_RST 16'h03E8
`define GRLS_ENERGY_RST 16'h0000
`define GRLS_CMD_TRACK_EN 16'h0021
`define GRLS_LS_NONE 8'h00
`define GRLS_LS_LEARNED_OFF 8'h02
`define GRLS_LS_ON_NONE 8'h04
`define GRLS_LS_ON_QMAX 8'h05
`define GRLS_LS_ON_BOTH 8'h06
// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define GRLS_CLK_HZ 10000000
`define GRLS_OCV_WAIT_S 16'h0168
`define GRLS_DVDT_MAX_UV 24'h00_0004
`define GRLS_UW_PER_MW 34'h0_0000_03E8
`define GRLS_DIV_STEPS 6'h30
`endif

// >>> core/grls_gauge.v
`timescale 1ns/1ps
`default_nettype none
`include "grls_consts.vh"

// Functional notes
// - Energy scale accepts only 1 through 10.
// - Energy values read scaled by energy scale.
// - Discharge flows only above discharge threshold.
// - Charge flows only above charge threshold.
// - Relax after small averaged current for time.
// - Relax after large averaged current, as printed.
// - Start OCV readings after six relax minutes.
// - Update capacity only when dV/dt below 4uV/s.
// - Leave relax after exit settle time above limit.
// - Capacity starts from loaded value, updates periodically.
// - Status 0x02 learned/off, 0x04 on/none.
// - Status 0x05 capacity only, 0x06 both learned.
// - Status changes only by learning or command.
// - Average discharge current stored per cycle.
// - Power averaged per cycle and stored.
// - Reserve energy with loaded or no-load compensation.
// - Select bit means no-load compensation, resets 0.
// - Tracking enabled by command code 0x0021.
module grls_gauge #(
  parameter CYC_PER_SEC = `GRLS_CLK_HZ
) (
  input wire sys_clk_i,
  input wire sys_rst_i,
  input wire [5:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [5:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire meas_valid_i,
  input wire signed [15:0] current_i,
  input wire [15:0] voltage_i,
  input wire [23:0] voltage_uv_i,
  input wire signed [15:0] averaged_current_i,
  input wire [15:0] qmax_calc_i,
  input wire resistance_table_learned_i,
  output reg dsg_flow_o,
  output reg chg_flow_o,
  output reg relax_o,
  output reg ocv_active_o,
  output reg noload_reserve_select_o,
  output reg [3:0] energy_scale_o
);

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  function [15:0] mag16;
    input [15:0] v;
    begin
      mag16 = v[15] ? (~v + 16'h0001) : v;
    end
  endfunction

  function [23:0] udiff24;
    input [23:0] a;
    input [23:0] b;
    begin
      udiff24 = (a > b) ? (a - b) : (b - a);
    end
  endfunction

  // ----------------------------------------------------------------------
  // Register bus
  // ----------------------------------------------------------------------
  reg [5:0] aw_addr_r;
  reg aw_hold_r;
  reg [31:0] w_data_r;
  reg [3:0] w_strb_r;
  reg w_hold_r;
  reg [15:0] dsg_th_r;
  reg [15:0] chg_th_r;
  reg [15:0] quit_r;
  reg [15:0] dsg_rlx_r;
  reg [15:0] chg_rlx_r;
  reg [15:0] quit_rlx_r;
  reg [15:0] rsv_e_r;
  reg [15:0] dsn_e_r;
  reg [15:0] qmax_r;
  reg [7:0] learn_r;
  reg [15:0] avg_i_last_r;
  reg [15:0] avg_p_last_r;
  reg dvdt_ok_r;
  wire do_write = aw_hold_r && w_hold_r && !s_axi_bvalid;
  wire wr_lo = w_strb_r[0];
  wire wr_hi = w_strb_r[1];
  wire [3:0] new_scale = w_data_r[`GRLS_CTRL_SCALE_HI:`GRLS_CTRL_SCALE_LO];
  wire track_cmd = do_write && (aw_addr_r == `GRLS_OFS_CMD) && wr_lo && wr_hi &&
                   (w_data_r[15:0] == `GRLS_CMD_TRACK_EN);
  wire [19:0] rsv_mwh = rsv_e_r * energy_scale_o;
  wire [19:0] dsn_mwh = dsn_e_r * energy_scale_o;

  always @(posedge sys_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
      aw_hold_r <= 1'b0;
      w_hold_r <= 1'b0;
      aw_addr_r <= 6'h00;
      w_data_r <= 32'h0000_0000;
      w_strb_r <= 4'h0;
      dsg_th_r <= `GRLS_TH_RST;
      chg_th_r <= `GRLS_TH_RST;
      quit_r <= `GRLS_QUIT_RST;
      dsg_rlx_r <= `GRLS_DSG_RLX_RST;
      chg_rlx_r <= `GRLS_CHG_RLX_RST;
      quit_rlx_r <= `GRLS_QUIT_RLX_RST;
      rsv_e_r <= `GRLS_ENERGY_RST;
      dsn_e_r <= `GRLS_ENERGY_RST;
      noload_reserve_select_o <= 1'b0;
      energy_scale_o <= `GRLS_SCALE_RST;
    end
    else
    begin
      s_axi_awready <= !aw_hold_r && !s_axi_awready && s_axi_awvalid;
      s_axi_wready <= !w_hold_r && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_hold_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_hold_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end
      if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
      if (do_write)
      begin
        aw_hold_r <= 1'b0;
        w_hold_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= 2'b00;
        case (aw_addr_r)
          `GRLS_OFS_CTRL:
          begin
            if (wr_lo)
              noload_reserve_select_o <= w_data_r[`GRLS_CTRL_NOLOAD];
            // Out-of-range scale writes are dropped, keeping the unit defined.
            if (wr_hi && new_scale >= `GRLS_SCALE_MIN && new_scale <= `GRLS_SCALE_MAX)
              energy_scale_o <= new_scale;
          end
          `GRLS_OFS_DSG_TH: if (wr_lo && wr_hi) dsg_th_r <= w_data_r[15:0];
          `GRLS_OFS_CHG_TH: if (wr_lo && wr_hi) chg_th_r <= w_data_r[15:0];
          `GRLS_OFS_QUIT: if (wr_lo && wr_hi) quit_r <= w_data_r[15:0];
          `GRLS_OFS_DSG_RLX: if (wr_lo && wr_hi) dsg_rlx_r <= w_data_r[15:0];
          `GRLS_OFS_CHG_RLX: if (wr_lo && wr_hi) chg_rlx_r <= w_data_r[15:0];
          `GRLS_OFS_QUIT_RLX: if (wr_lo && wr_hi) quit_rlx_r <= w_data_r[15:0];
          `GRLS_OFS_RSV_E: if (wr_lo && wr_hi) rsv_e_r <= w_data_r[15:0];
          `GRLS_OFS_DSN_E: if (wr_lo && wr_hi) dsn_e_r <= w_data_r[15:0];
          `GRLS_OFS_CMD, `GRLS_OFS_QMAX:
            s_axi_bresp <= 2'b00;
          default:
            s_axi_bresp <= 2'b10;
        endcase
      end
    end
  end

  always @(posedge sys_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'b00;
    end
    else
    begin
      s_axi_arready <= !s_axi_rvalid && !s_axi_arready && s_axi_arvalid;
      if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= 2'b00;
        s_axi_rdata <= 32'h0000_0000;
        case (s_axi_araddr)
          `GRLS_OFS_CTRL: s_axi_rdata <= {20'h0_0000, energy_scale_o, 7'h00, noload_reserve_select_o};
          `GRLS_OFS_DSG_TH: s_axi_rdata <= {16'h0000, dsg_th_r};
          `GRLS_OFS_CHG_TH: s_axi_rdata <= {16'h0000, chg_th_r};
          `GRLS_OFS_QUIT: s_axi_rdata <= {16'h0000, quit_r};
          `GRLS_OFS_DSG_RLX: s_axi_rdata <= {16'h0000, dsg_rlx_r};
          `GRLS_OFS_CHG_RLX: s_axi_rdata <= {16'h0000, chg_rlx_r};
          `GRLS_OFS_QUIT_RLX: s_axi_rdata <= {16'h0000, quit_rlx_r};
          `GRLS_OFS_CMD: s_axi_rdata <= 32'h0000_0000;
          `GRLS_OFS_STATUS: s_axi_rdata <= {16'h0000, learn_r, 3'b000, dvdt_ok_r, ocv_active_o,
                                            relax_o, chg_flow_o, dsg_flow_o};
          `GRLS_OFS_QMAX: s_axi_rdata <= {16'h0000, qmax_r};
          `GRLS_OFS_AVG_I: s_axi_rdata <= {16'h0000, avg_i_last_r};
          `GRLS_OFS_AVG_P: s_axi_rdata <= {16'h0000, avg_p_last_r};
          `GRLS_OFS_RSV_E: s_axi_rdata <= {16'h0000, rsv_e_r};
          `GRLS_OFS_DSN_E: s_axi_rdata <= {16'h0000, dsn_e_r};
          `GRLS_OFS_RSV_MWH: s_axi_rdata <= {12'h000, rsv_mwh};
          `GRLS_OFS_DSN_MWH: s_axi_rdata <= {12'h000, dsn_mwh};
          default: s_axi_rresp <= 2'b10;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------------
  // One-second tick and current direction
  // ----------------------------------------------------------------------
  reg [31:0] div_cnt_r;
  reg sec_tick_r;
  wire [15:0] dsg_mag = current_i[15] ? mag16(current_i) : 16'h0000;
  wire [15:0] chg_mag = current_i[15] ? 16'h0000 : current_i;
  wire [15:0] avg_mag = mag16(averaged_current_i);
  wire [15:0] quit_mag = mag16(quit_r);

  always @(posedge sys_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      div_cnt_r <= 32'h0000_0000;
      sec_tick_r <= 1'b0;
      dsg_flow_o <= 1'b0;
      chg_flow_o <= 1'b0;
    end
    else
    begin
      sec_tick_r <= (div_cnt_r == CYC_PER_SEC - 1);
      div_cnt_r <= (div_cnt_r == CYC_PER_SEC - 1) ? 32'h0000_0000 : div_cnt_r + 32'h0000_0001;
      if (meas_valid_i)
      begin
        dsg_flow_o <= dsg_mag > dsg_th_r;
        chg_flow_o <= chg_mag > chg_th_r;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Relaxation state, OCV timer and voltage stability
  // ----------------------------------------------------------------------
  reg [15:0] low_sec_r;
  reg [15:0] high_sec_r;
  reg [15:0] exit_sec_r;
  reg [15:0] ocv_sec_r;
  reg [23:0] v_prev_r;
  wire below = avg_mag < quit_mag;
  wire above = avg_mag > quit_mag;

  always @(posedge sys_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      low_sec_r <= 16'h0000;
      high_sec_r <= 16'h0000;
      exit_sec_r <= 16'h0000;
      ocv_sec_r <= 16'h0000;
      relax_o <= 1'b0;
      ocv_active_o <= 1'b0;
      v_prev_r <= 24'h00_0000;
      dvdt_ok_r <= 1'b0;
    end
    else if (sec_tick_r)
    begin
      v_prev_r <= voltage_uv_i;
      dvdt_ok_r <= udiff24(voltage_uv_i, v_prev_r) < `GRLS_DVDT_MAX_UV;
      low_sec_r <= below ? low_sec_r + 16'h0001 : 16'h0000;
      high_sec_r <= above ? high_sec_r + 16'h0001 : 16'h0000;
      exit_sec_r <= (relax_o && above) ? exit_sec_r + 16'h0001 : 16'h0000;
      if (!relax_o)
      begin
        ocv_sec_r <= 16'h0000;
        ocv_active_o <= 1'b0;
        if ((below && low_sec_r + 16'h0001 >= dsg_rlx_r) ||
            (above && high_sec_r + 16'h0001 >= chg_rlx_r))
          relax_o <= 1'b1;
      end
      else
      begin
        if (above && exit_sec_r + 16'h0001 >= quit_rlx_r)
        begin
          relax_o <= 1'b0;
          ocv_active_o <= 1'b0;
        end
        else if (ocv_sec_r + 16'h0001 >= `GRLS_OCV_WAIT_S)
          ocv_active_o <= 1'b1;
        else
          ocv_sec_r <= ocv_sec_r + 16'h0001;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Capacity learning and learning status
  // ----------------------------------------------------------------------
  wire tracking_on = learn_r[2];
  wire qmax_upd = sec_tick_r && ocv_active_o && relax_o && dvdt_ok_r && tracking_on;

  always @(posedge sys_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      qmax_r <= `GRLS_QMAX_RST;
      learn_r <= `GRLS_LS_NONE;
    end
    else
    begin
      if (do_write && aw_addr_r == `GRLS_OFS_QMAX && wr_lo && wr_hi)
        qmax_r <= w_data_r[15:0];
      else if (qmax_upd)
        qmax_r <= qmax_calc_i;
      if (track_cmd)
        learn_r <= (learn_r == `GRLS_LS_LEARNED_OFF) ? `GRLS_LS_ON_BOTH : `GRLS_LS_ON_NONE;
      else if (qmax_upd && learn_r == `GRLS_LS_ON_NONE)
        learn_r <= `GRLS_LS_ON_QMAX;
      else if (resistance_table_learned_i && learn_r == `GRLS_LS_ON_QMAX)
        learn_r <= `GRLS_LS_ON_BOTH;
    end
  end

  // ----------------------------------------------------------------------
  // Discharge-run averages
  // ----------------------------------------------------------------------
  // One shared serial divider keeps area small; results land ~100 cycles after the run.
  localparam ST_IDLE = 2'd0;
  localparam ST_DIV_I = 2'd1;
  localparam ST_DIV_P = 2'd2;
  reg [1:0] st_r;
  reg dsg_prev_r;
  reg [47:0] sum_i_r;
  reg [47:0] sum_p_r;
  reg [23:0] cnt_r;
  reg [47:0] quo_r;
  reg [47:0] rem_r;
  reg [5:0] step_r;
  wire [31:0] pwr_uw = dsg_mag * voltage_i;
  wire [47:0] divisor = (st_r == ST_DIV_P) ? {14'h0000, cnt_r * `GRLS_UW_PER_MW} :
                        {24'h00_0000, cnt_r};
  wire [47:0] rem_sh = {rem_r[46:0], quo_r[47]};

  always @(posedge sys_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      st_r <= ST_IDLE;
      dsg_prev_r <= 1'b0;
      sum_i_r <= 48'h0000_0000_0000;
      sum_p_r <= 48'h0000_0000_0000;
      cnt_r <= 24'h00_0000;
      quo_r <= 48'h0000_0000_0000;
      rem_r <= 48'h0000_0000_0000;
      step_r <= 6'h00;
      avg_i_last_r <= 16'h0000;
      avg_p_last_r <= 16'h0000;
    end
    else
    begin
      dsg_prev_r <= dsg_flow_o;
      case (st_r)
        ST_IDLE:
        begin
          if (dsg_flow_o && !dsg_prev_r)
          begin
            sum_i_r <= 48'h0000_0000_0000;
            sum_p_r <= 48'h0000_0000_0000;
            cnt_r <= 24'h00_0000;
          end
          else if (dsg_flow_o && meas_valid_i && dsg_mag > dsg_th_r)
          begin
            sum_i_r <= sum_i_r + {32'h0000_0000, dsg_mag};
            sum_p_r <= sum_p_r + {16'h0000, pwr_uw};
            cnt_r <= cnt_r + 24'h00_0001;
          end
          else if (!dsg_flow_o && dsg_prev_r && cnt_r != 24'h00_0000)
          begin
            quo_r <= sum_i_r;
            rem_r <= 48'h0000_0000_0000;
            step_r <= 6'h00;
            st_r <= ST_DIV_I;
          end
        end
        ST_DIV_I, ST_DIV_P:
        begin
          if (rem_sh >= divisor)
          begin
            rem_r <= rem_sh - divisor;
            quo_r <= {quo_r[46:0], 1'b1};
          end
          else
          begin
            rem_r <= rem_sh;
            quo_r <= {quo_r[46:0], 1'b0};
          end
          step_r <= step_r + 6'h01;
          if (step_r == `GRLS_DIV_STEPS - 6'h01)
          begin
            step_r <= 6'h00;
            rem_r <= 48'h0000_0000_0000;
            if (st_r == ST_DIV_I)
            begin
              avg_i_last_r <= {quo_r[14:0], rem_sh >= divisor};
              quo_r <= sum_p_r;
              st_r <= ST_DIV_P;
            end
            else
            begin
              avg_p_last_r <= {quo_r[14:0], rem_sh >= divisor};
              st_r <= ST_IDLE;
            end
          end
        end
        default:
          st_r <= ST_IDLE;
      endcase
    end
  end

endmodule
`default_nettype wire

// >>> tb/grls_gauge_properties.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// Port-level checks of the gauge bookkeeping block
// ----------------------------------------------------------------
module grls_chk #(
  parameter int CYC_PER_SEC = 10
) (
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic meas_valid_i,
  input wire logic signed [15:0] current_i,
  input wire logic dsg_flow_o,
  input wire logic chg_flow_o,
  input wire logic relax_o,
  input wire logic ocv_active_o,
  input wire logic noload_reserve_select_o,
  input wire logic [3:0] energy_scale_o
);
  // One second of slack: relax entry and the OCV phase move on 1 s ticks.
  localparam int OCV_MIN = 359 * CYC_PER_SEC;
  logic [31:0] rlx_cnt_r;
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (sys_rst_i);
  always_ff @(posedge sys_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      rlx_cnt_r <= 32'h0000_0000;
    else
      rlx_cnt_r <= relax_o ? rlx_cnt_r + 32'h0000_0001 : 32'h0000_0000;
  end
  AST_SCALE_RANGE: assert property (energy_scale_o >= 4'h1 && energy_scale_o <= 4'hA)
    else $error("energy scale outside 1 to 10");
  AST_FLOW_EXCL: assert property (!(dsg_flow_o && chg_flow_o))
    else $error("charge and discharge flow flagged together");
  AST_FLOW_HOLD: assert property (!$past(meas_valid_i) |-> $stable(dsg_flow_o) && $stable(chg_flow_o))
    else $error("flow flag moved without a sample");
  AST_DSG_SIGN: assert property (meas_valid_i && !current_i[15] |=> !dsg_flow_o)
    else $error("discharge flagged on non-negative current");
  AST_CHG_SIGN: assert property (meas_valid_i && (current_i[15] || current_i == 16'h0000) |=> !chg_flow_o)
    else $error("charge flagged on non-positive current");
  AST_OCV_DELAY: assert property ($rose(ocv_active_o) |-> relax_o && rlx_cnt_r >= OCV_MIN)
    else $error("OCV phase began too early");
  AST_OCV_DROP: assert property ($fell(relax_o) |-> ##[0:1] !ocv_active_o)
    else $error("OCV phase outlived relaxation");
  AST_B_ANSWER: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write response late");
  AST_R_ANSWER: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped before accepted");
  AST_CFG_BY_WRITE: assert property ($changed(energy_scale_o) || $changed(noload_reserve_select_o) |->
    s_axi_wready || $past(s_axi_wready) || s_axi_bvalid)
    else $error("configuration output moved without a write");
endmodule
bind grls_gauge grls_chk #(.CYC_PER_SEC(CYC_PER_SEC)) u_chk (.*);
`default_nettype wire

// >>> tb/grls_fe_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// Measurement front end: one sample per PERIOD cycles
// ----------------------------------------------------------------
module grls_fe #(
  parameter int PERIOD = 10
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic signed [15:0] cur_set_i,
  input wire logic signed [15:0] avg_set_i,
  input wire logic [15:0] mv_set_i,
  input wire logic [23:0] slope_set_i,
  output logic meas_valid_o,
  output logic signed [15:0] current_o,
  output logic signed [15:0] avg_o,
  output logic [15:0] voltage_o,
  output logic [23:0] uv_o
);
  logic [7:0] cnt_r;
  wire logic hit = (cnt_r == 8'(PERIOD - 1));
  // Between samples current and voltage show the inverse to expose stale reads.
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      cnt_r <= 8'h00;
      meas_valid_o <= 1'b0;
      current_o <= 16'h0000;
      avg_o <= 16'h0000;
      voltage_o <= 16'h0000;
      uv_o <= 24'h3D_0900;
    end
    else
    begin
      cnt_r <= hit ? 8'h00 : cnt_r + 8'h01;
      meas_valid_o <= hit;
      current_o <= hit ? cur_set_i : ~cur_set_i;
      voltage_o <= hit ? mv_set_i : ~mv_set_i;
      avg_o <= avg_set_i;
      if (hit)
        uv_o <= uv_o + slope_set_i;
    end
  end
endmodule
`default_nettype wire

// >>> tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`include "grls_consts.vh"
// ----------------------------------------------------------------
// Self-checking bench
// ----------------------------------------------------------------
module testbench;
  localparam int CPS = 10;
  logic sys_clk_i, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, meas_valid_i;
  logic dsg_flow_o, chg_flow_o, relax_o, ocv_active_o, noload_reserve_select_o;
  logic sys_rst_i = 1'b1, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0, resistance_table_learned_i = 1'b0;
  logic [5:0] s_axi_awaddr = 6'h00, s_axi_araddr = 6'h00;
  logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata, d;
  logic [3:0] s_axi_wstrb = 4'hF, energy_scale_o, es;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic signed [15:0] current_i, averaged_current_i, cur_set = 16'h0000, avg_set = 16'h0000;
  logic [15:0] voltage_i, qmax_calc_i = 16'h0000, mv_set = 16'h3A98, q;
  logic [23:0] voltage_uv_i, slope_set = 24'h00_0000;
  logic [15:0] rst_tab [16] = '{16'h0100, 16'h0064, 16'h0064, 16'h000A, 16'h003C, 16'h003C, 16'h0001, 16'h0000,
    16'h0010, 16'h03E8, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000};
  int miscompares, n_tests, cyc, c, td, tc, ia, mv, n;
  grls_gauge #(.CYC_PER_SEC(CPS)) DUT (.*);
  grls_fe #(.PERIOD(CPS)) u_fe (.clk_i(sys_clk_i), .rst_i(sys_rst_i), .cur_set_i(cur_set), .avg_set_i(avg_set),
    .mv_set_i(mv_set), .slope_set_i(slope_set), .meas_valid_o(meas_valid_i), .current_o(current_i),
    .avg_o(averaged_current_i), .voltage_o(voltage_i), .uv_o(voltage_uv_i));
  function automatic logic [1:0] flows(int cur, int thd, int thc);
    return {(-cur) > thd, cur > thc};
  endfunction
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, exp, input string what);
    n_tests++;
    if (got !== exp)
    begin
      miscompares++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic axi_wr(input logic [5:0] a, input logic [31:0] dat);
    bit aw_ok = 1'b0, w_ok = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= dat;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw_ok && w_ok))
    begin
      @(posedge sys_clk_i);
      aw_ok |= s_axi_awready;
      w_ok |= s_axi_wready;
      s_axi_awvalid <= !aw_ok;
      s_axi_wvalid <= !w_ok;
    end
    do @(posedge sys_clk_i); while (s_axi_bvalid !== 1'b1);
  endtask
  // Ready is raised after the data shows, so the slave must hold it.
  task automatic axi_rd(input logic [5:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge sys_clk_i); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge sys_clk_i); while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b1;
    @(posedge sys_clk_i);
    d = s_axi_rdata;
    s_axi_rready <= 1'b0;
  endtask
  task automatic rchk(input logic [5:0] a, input logic [31:0] exp, input string what);
    axi_rd(a);
    chk(d, exp, what);
  endtask
  task automatic wait_lvl(input int w, input int lim);
    n = 0;
    while (n < lim && (w == 0 ? relax_o : w == 1 ? ocv_active_o : !relax_o) !== 1'b1)
    begin
      @(posedge sys_clk_i);
      n++;
    end
  endtask
  initial
  begin
    sys_clk_i = 1'b0;
    forever #50 sys_clk_i = ~sys_clk_i;
  end
  always @(posedge sys_clk_i)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      miscompares++;
      print_verdict();
    end
  end
  initial
  begin
    void'($urandom(32'h1558dc51));
    repeat (12) @(posedge sys_clk_i);
    sys_rst_i <= 1'b0;
    @(posedge sys_clk_i);
    chk(noload_reserve_select_o, 1'b0, "noload after reset");
    for (int i = 0; i < 16; i++)
      rchk(6'(i * 4), {16'h0000, rst_tab[i]}, "reset value");
    $display("test reset done");
    es = 4'h1;
    for (int v = 15; v >= 0; v--)
    begin
      axi_wr(`GRLS_OFS_CTRL, {20'h0_0000, v[3:0], 8'h00});
      es = (v >= 1 && v <= 10) ? v[3:0] : es;
      chk(energy_scale_o, es, "scale");
    end
    for (int k = 0; k < 2; k++)
    begin
      es = 4'($urandom_range(10, 1));
      q = 16'($urandom_range(16'h0FFF, 1));
      axi_wr(`GRLS_OFS_CTRL, {20'h0_0000, es, 8'h01});
      chk(noload_reserve_select_o, 1'b1, "noload set");
      axi_wr(`GRLS_OFS_RSV_E, q);
      axi_wr(`GRLS_OFS_DSN_E, q + 16'h0001);
      rchk(`GRLS_OFS_RSV_MWH, q * es, "scaled reserve");
      rchk(`GRLS_OFS_DSN_MWH, (q + 1) * es, "scaled design energy");
    end
    axi_wr(`GRLS_OFS_CTRL, 32'h0000_0100);
    chk(noload_reserve_select_o, 1'b0, "noload clear");
    $display("test scale done");
    td = $urandom_range(200, 20);
    tc = $urandom_range(200, 20);
    axi_wr(`GRLS_OFS_DSG_TH, td);
    axi_wr(`GRLS_OFS_CHG_TH, tc);
    for (int k = 0; k < 12; k++)
    begin
      c = k == 0 ? -td : k == 1 ? -td - 1 : k == 2 ? tc : k == 3 ? tc + 1 : int'($urandom_range(600)) - 300;
      cur_set <= 16'(c);
      repeat (25) @(posedge sys_clk_i);
      chk({dsg_flow_o, chg_flow_o}, flows(c, td, tc), "flow flags");
    end
    cur_set <= 16'h0000;
    repeat (200) @(posedge sys_clk_i);
    $display("test flow done");
    for (int k = 0; k < 2; k++)
    begin
      ia = $urandom_range(3000, 300);
      mv = $urandom_range(20000, 3000);
      mv_set <= 16'(mv);
      cur_set <= 16'(-ia);
      repeat (300) @(posedge sys_clk_i);
      cur_set <= 16'h0000;
      repeat (200) @(posedge sys_clk_i);
      rchk(`GRLS_OFS_AVG_P, ia * mv / 1000, "last run power");
      axi_rd(`GRLS_OFS_AVG_I);
      chk(d, ia, "last run current");
    end
    $display("test averages done");
    axi_wr(`GRLS_OFS_DSG_RLX, 32'h0000_0005);
    axi_wr(`GRLS_OFS_CHG_RLX, 32'h0000_FFFF);
    axi_wr(`GRLS_OFS_QUIT_RLX, 32'h0000_0002);
    axi_wr(`GRLS_OFS_CMD, `GRLS_CMD_TRACK_EN);
    rchk(`GRLS_OFS_STATUS, 32'h0000_0414, "tracking on");
    axi_wr(`GRLS_OFS_CMD, 32'h0000_0022);
    axi_wr(`GRLS_OFS_STATUS, 32'h0000_FFFF);
    rchk(`GRLS_OFS_STATUS, 32'h0000_0414, "status untouched");
    slope_set <= 24'h00_0032;
    avg_set <= 16'sd100;
    wait_lvl(2, 60);
    chk(relax_o, 1'b0, "relax exit");
    avg_set <= 16'sd5;
    repeat (30) @(posedge sys_clk_i);
    avg_set <= 16'sd100;
    repeat (15) @(posedge sys_clk_i);
    avg_set <= -16'sd5;
    repeat (30) @(posedge sys_clk_i);
    chk(relax_o, 1'b0, "entry timer restarted");
    wait_lvl(0, 40);
    chk(relax_o, 1'b1, "relax entry");
    wait_lvl(1, 3800);
    chk(32'(n > 3500 && n < 3700), 32'h0000_0001, "ocv start");
    repeat (30) @(posedge sys_clk_i);
    rchk(`GRLS_OFS_STATUS, 32'h0000_040C, "unstable voltage");
    rchk(`GRLS_OFS_QMAX, `GRLS_QMAX_RST, "capacity held");
    q = 16'($urandom());
    qmax_calc_i <= q;
    slope_set <= 24'h00_0000;
    repeat (60) @(posedge sys_clk_i);
    rchk(`GRLS_OFS_STATUS, 32'h0000_051C, "capacity learned");
    rchk(`GRLS_OFS_QMAX, q, "capacity updated");
    resistance_table_learned_i <= 1'b1;
    @(posedge sys_clk_i);
    resistance_table_learned_i <= 1'b0;
    repeat (3) @(posedge sys_clk_i);
    rchk(`GRLS_OFS_STATUS, 32'h0000_061C, "both learned");
    avg_set <= 16'sd100;
    repeat (10) @(posedge sys_clk_i);
    chk(relax_o, 1'b1, "exit not before settle time");
    wait_lvl(2, 40);
    chk({relax_o, ocv_active_o}, 2'b00, "relax left");
    axi_wr(`GRLS_OFS_CMD, `GRLS_CMD_TRACK_EN);
    rchk(`GRLS_OFS_STATUS, 32'h0000_0410, "tracking restart");
    axi_wr(`GRLS_OFS_CHG_RLX, 32'h0000_0002);
    wait_lvl(0, 60);
    chk(relax_o, 1'b1, "relax on large current");
    q = 16'($urandom());
    axi_wr(`GRLS_OFS_QMAX, q);
    rchk(`GRLS_OFS_QMAX, q, "capacity loaded");
    $display("test relax done");
    print_verdict();
  end
endmodule
`default_nettype wire
